// ===== rtl/clk_ctrl_pkg.sv
package clk_ctrl_pkg;

   // ***********************************************************
   // Power and switch states
   // ***********************************************************
   typedef enum logic [1:0] {
      PM_STANDBY = 2'b00,
      PM_ACTIVE  = 2'b01,
      PM_SLEEP   = 2'b10
   } power_mode_t;

   typedef enum logic [0:0] {
      SW_IDLE  = 1'b0,
      SW_BREAK = 1'b1
   } switch_state_t;

   // ***********************************************************
   // Serial frame layout
   // ***********************************************************
   localparam int         FRAME_BITS    = 24;
   localparam int         HEAD_BITS     = 8;
   localparam int         CMD_TAIL_BITS = 16;
   localparam logic [1:0] CMD_PREFIX    = 2'b01;
   localparam logic [23:0] WAKE_FRAME   = 24'h000000;

   // ***********************************************************
   // Command codes (whole first byte)
   // ***********************************************************
   localparam logic [7:0] STANDBY_CODE       = 8'h41;
   localparam logic [7:0] SLEEP_CODE         = 8'h42;
   localparam logic [7:0] EXTERNAL_SRC_CODE  = 8'h44;
   localparam logic [7:0] INTERNAL_SRC_CODE  = 8'h48;
   localparam logic [7:0] pll_high_freq_code = 8'h62;
   localparam logic [7:0] pll_low_freq_code  = 8'h61;

   // ***********************************************************
   // Frequencies and reset values
   // ***********************************************************
   localparam int         REF_CLOCK_MHZ  = 12;
   localparam int         HIGH_FREQ_MHZ  = 48;
   localparam int         LOW_FREQ_MHZ   = 36;
   localparam logic [2:0] HIGH_MULT      = 3'(HIGH_FREQ_MHZ / REF_CLOCK_MHZ);
   localparam logic [2:0] LOW_MULT       = 3'(LOW_FREQ_MHZ / REF_CLOCK_MHZ);
   localparam logic       RESET_FREQ_HIGH = 1'b1;
   localparam logic       RESET_SRC_EXT   = 1'b0;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int MCLK_NS    = 40;
   localparam int GAP_NS     = 100;
   localparam int GAP_CYCLES = (GAP_NS + MCLK_NS - 1) / MCLK_NS;

endpackage : clk_ctrl_pkg

// ===== rtl/link_frame_receiver.sv
`timescale 1ns/10ps
module link_frame_receiver #(
   parameter int FRAME_BITS = clk_ctrl_pkg::FRAME_BITS
) (
   input  wire logic                  sclk,
   input  wire logic                  rst_n,
   input  wire logic                  cs_n,
   input  wire logic                  mosi,
   output logic [FRAME_BITS-1:0]      frame,
   output logic                       done_tgl
);

   localparam int             CW   = $clog2(FRAME_BITS + 1);
   localparam logic [CW-1:0]  FULL = CW'(FRAME_BITS);
   localparam logic [CW-1:0]  LAST = CW'(FRAME_BITS - 1);

   logic [CW-1:0]         bit_cnt;
   logic [FRAME_BITS-1:0] shift;
   wire                   counting = bit_cnt != FULL;
   wire                   last_bit = bit_cnt == LAST;

   // ***********************************************************
   // Bit counter, cleared by the frame select going high
   // ***********************************************************
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt <= '0;
      end else if (counting) begin
         bit_cnt <= bit_cnt + CW'(1);
      end
   end

   // Shift in msb first, stop after the header bytes
   always_ff @(posedge sclk) begin
      if (counting) begin
         shift <= {shift[FRAME_BITS-2:0], mosi};
      end
   end

   // Capture the header and flag it by a toggle
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         frame    <= '0;
         done_tgl <= 1'b0;
      end else if (last_bit) begin
         frame    <= {shift[FRAME_BITS-2:0], mosi};
         done_tgl <= ~done_tgl;
      end
   end

endmodule : link_frame_receiver

// ===== rtl/system_clock_control.sv
`timescale 1ns/10ps
// Functional notes
// - Sources: internal oscillator, external crystal, external square wave.
// - Source select commands switch internal/external on the fly at vsync.
// - PLL takes the selected oscillator and clocks every internal engine.
// - Power-on in standby, clock gated; wake read of address 0 enables it.
// - Default system clock is 48MHz from 12MHz input.
// - Frequency commands select 48MHz or 36MHz PLL output.
// - Frequency change applied on a vsync edge to avoid display glitch.
// - Pending switch applies only while pixel divisor is non-zero.
// - Commands are three bytes: prefix 01, six-bit code, two zero bytes.
// - Codes 44h external source, 62h 48MHz, 61h 36MHz.
// - Dummy read of address 0 in sleep or standby returns to active.
// - Standby gates core clock only; sleep also stops PLL and oscillator.
module system_clock_control #(
   parameter int PCLK_W     = 8,
   parameter int GAP_CYCLES = clk_ctrl_pkg::GAP_CYCLES
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              sclk,
   input  wire logic              cs_n,
   input  wire logic              mosi,
   input  wire logic              xtal_bypass,
   input  wire logic              vsync,
   input  wire logic [PCLK_W-1:0] pclk_div,
   output logic                   core_clk_en,
   output logic                   pll_en,
   output logic                   osc_en,
   output logic                   xtal_amp_en,
   output logic                   pll_ref_ext,
   output logic [2:0]             pll_mult,
   output logic                   clk_sel_int,
   output logic                   clk_sel_ext,
   output logic                   switch_pending
);

   localparam int            FB  = clk_ctrl_pkg::FRAME_BITS;
   localparam int            GW  = $clog2(GAP_CYCLES + 1);
   localparam logic [GW-1:0] GAP_LOAD = GW'(GAP_CYCLES - 1);

   // ***********************************************************
   // Link side: serial header capture on the link clock
   // ***********************************************************
   logic [FB-1:0] frame;
   logic          done_tgl;

   link_frame_receiver #(
      .FRAME_BITS (FB)
   ) u_rx (
      .sclk     (sclk),
      .rst_n    (rst_n),
      .cs_n     (cs_n),
      .mosi     (mosi),
      .frame    (frame),
      .done_tgl (done_tgl)
   );

   // ***********************************************************
   // Crossing into the system clock domain
   // ***********************************************************
   logic [1:0] tgl_sync;
   logic [1:0] strap_sync;
   logic       tgl_seen;

   // Two-stage synchronisers for frame toggle and strap pin
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tgl_sync   <= 2'h0;
         strap_sync <= 2'h0;
      end else if (ce) begin
         tgl_sync   <= {tgl_sync[0], done_tgl};
         strap_sync <= {strap_sync[0], xtal_bypass};
      end
   end

   // Last toggle level already acted on
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tgl_seen <= 1'b0;
      end else if (ce) begin
         tgl_seen <= tgl_sync[1];
      end
   end

   // Frame word is stable for many cycles once the toggle is seen
   wire frame_evt = ce && (tgl_sync[1] ^ tgl_seen);

   // ***********************************************************
   // Command decode
   // ***********************************************************
   wire [7:0] frame_head = frame[FB-1 -: clk_ctrl_pkg::HEAD_BITS];
   wire [clk_ctrl_pkg::CMD_TAIL_BITS-1:0] frame_tail =
      frame[clk_ctrl_pkg::CMD_TAIL_BITS-1:0];

   // Wake is the read header of address 0
   wire is_wake = frame_evt && frame == clk_ctrl_pkg::WAKE_FRAME;
   // Command form: prefix 01 and two zero trailing bytes
   wire is_cmd  = frame_evt && frame_head[7:6] == clk_ctrl_pkg::CMD_PREFIX
                  && frame_tail == '0;

   // Individual command strobes
   wire standby_cmd = is_cmd && frame_head == clk_ctrl_pkg::STANDBY_CODE;
   wire sleep_cmd   = is_cmd && frame_head == clk_ctrl_pkg::SLEEP_CODE;
   wire select_external_clock_cmd =
      is_cmd && frame_head == clk_ctrl_pkg::EXTERNAL_SRC_CODE;
   wire select_internal_clock_cmd =
      is_cmd && frame_head == clk_ctrl_pkg::INTERNAL_SRC_CODE;
   wire pll_high_freq_cmd =
      is_cmd && frame_head == clk_ctrl_pkg::pll_high_freq_code;
   wire pll_low_freq_cmd  =
      is_cmd && frame_head == clk_ctrl_pkg::pll_low_freq_code;

   // Grouped strobes; anything else is dropped
   wire src_cmd   = select_external_clock_cmd || select_internal_clock_cmd;
   wire freq_cmd  = pll_high_freq_cmd || pll_low_freq_cmd;
   wire known_cmd = src_cmd || freq_cmd || standby_cmd || sleep_cmd;

   // ***********************************************************
   // Power mode machine
   // ***********************************************************
   clk_ctrl_pkg::power_mode_t pm;
   clk_ctrl_pkg::power_mode_t next_pm;

   // Mode transitions from wake, standby and sleep requests
   always_comb begin
      next_pm = pm;
      unique case (pm)
         clk_ctrl_pkg::PM_STANDBY: begin
            if (is_wake) begin
               next_pm = clk_ctrl_pkg::PM_ACTIVE;
            end else if (sleep_cmd) begin
               next_pm = clk_ctrl_pkg::PM_SLEEP;
            end
         end
         clk_ctrl_pkg::PM_ACTIVE: begin
            if (standby_cmd) begin
               next_pm = clk_ctrl_pkg::PM_STANDBY;
            end else if (sleep_cmd) begin
               next_pm = clk_ctrl_pkg::PM_SLEEP;
            end
         end
         clk_ctrl_pkg::PM_SLEEP: begin
            if (is_wake) begin
               next_pm = clk_ctrl_pkg::PM_ACTIVE;
            end
         end
         default: begin
            next_pm = clk_ctrl_pkg::PM_STANDBY;
         end
      endcase
   end

   // Power-on lands in standby with the core clock gated
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pm <= clk_ctrl_pkg::PM_STANDBY;
      end else if (ce) begin
         pm <= next_pm;
      end
   end

   // ***********************************************************
   // Pending source and frequency requests
   // ***********************************************************
   logic pend_src;
   logic pend_src_ext;
   logic pend_freq;
   logic pend_freq_high;
   logic vsync_q;

   // Vertical sync comes from display timing on this clock
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         vsync_q <= 1'b0;
      end else if (ce) begin
         vsync_q <= vsync;
      end
   end

   clk_ctrl_pkg::switch_state_t sw;
   wire vsync_rise = vsync && !vsync_q;
   wire pclk_nz    = pclk_div != '0;
   // Switch only on a vsync edge with a running pixel clock
   wire apply = ce && vsync_rise && pclk_nz && (pend_src || pend_freq)
                && sw == clk_ctrl_pkg::SW_IDLE;

   // A new request in the apply cycle stays pending
   wire next_pend_src  = src_cmd  ? 1'b1 : (apply ? 1'b0 : pend_src);
   wire next_pend_freq = freq_cmd ? 1'b1 : (apply ? 1'b0 : pend_freq);

   // Held until the next usable vsync edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pend_src       <= 1'b0;
         pend_src_ext   <= clk_ctrl_pkg::RESET_SRC_EXT;
         pend_freq      <= 1'b0;
         pend_freq_high <= clk_ctrl_pkg::RESET_FREQ_HIGH;
      end else if (ce) begin
         pend_src  <= next_pend_src;
         pend_freq <= next_pend_freq;
         if (src_cmd) begin
            pend_src_ext <= select_external_clock_cmd;
         end
         if (freq_cmd) begin
            pend_freq_high <= pll_high_freq_cmd;
         end
      end
   end

   // ***********************************************************
   // Applied clock configuration and break-before-make switch
   // ***********************************************************
   logic          src_ext;
   logic          freq_high;
   logic [GW-1:0] gap_cnt;

   // Both mux legs stay off for the gap, then the new leg opens
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sw      <= clk_ctrl_pkg::SW_IDLE;
         gap_cnt <= '0;
      end else if (ce) begin
         if (apply) begin
            sw      <= clk_ctrl_pkg::SW_BREAK;
            gap_cnt <= GAP_LOAD;
         end else if (sw == clk_ctrl_pkg::SW_BREAK) begin
            if (gap_cnt == '0) begin
               sw <= clk_ctrl_pkg::SW_IDLE;
            end else begin
               gap_cnt <= gap_cnt - GW'(1);
            end
         end
      end
   end

   // Selection taken over on the vsync edge only
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         src_ext   <= clk_ctrl_pkg::RESET_SRC_EXT;
         freq_high <= clk_ctrl_pkg::RESET_FREQ_HIGH;
      end else if (apply) begin
         if (pend_src) begin
            src_ext <= pend_src_ext;
         end
         if (pend_freq) begin
            freq_high <= pend_freq_high;
         end
      end
   end

   // ***********************************************************
   // Outputs to oscillator, PLL, mux and clock gate
   // ***********************************************************
   wire sw_idle = sw == clk_ctrl_pkg::SW_IDLE;

   // Sleep stops oscillator and PLL; standby only gates the core
   assign osc_en      = pm != clk_ctrl_pkg::PM_SLEEP;
   assign pll_en      = pm != clk_ctrl_pkg::PM_SLEEP;
   assign core_clk_en = pm == clk_ctrl_pkg::PM_ACTIVE && sw_idle;
   // Crystal amplifier off when a square wave is strapped in
   assign xtal_amp_en = osc_en && src_ext && !strap_sync[1];
   assign pll_ref_ext = src_ext;
   assign pll_mult    = freq_high ? clk_ctrl_pkg::HIGH_MULT
                                  : clk_ctrl_pkg::LOW_MULT;
   // One mux leg at a time, none during the gap
   assign clk_sel_int = sw_idle && !src_ext;
   assign clk_sel_ext = sw_idle && src_ext;
   assign switch_pending = pend_src || pend_freq;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_apply;
      apply;
   endsequence

   sequence s_gap;
      !clk_sel_int && !clk_sel_ext;
   endsequence

   a_wake_active: assert property (is_wake |=>
      pm == clk_ctrl_pkg::PM_ACTIVE && core_clk_en)
      else $error("wake read did not activate the core clock");

   a_standby_gate: assert property (standby_cmd &&
      pm == clk_ctrl_pkg::PM_ACTIVE |=> !core_clk_en && pll_en && osc_en)
      else $error("standby did not gate core clock alone");

   a_sleep_stop: assert property (sleep_cmd |=>
      !pll_en && !osc_en && !core_clk_en)
      else $error("sleep left PLL or oscillator running");

   a_zero_pclk: assert property (pclk_div == '0 |=>
      $stable(src_ext) && $stable(freq_high))
      else $error("clock switched with zero pixel divisor");

   a_vsync_aligned: assert property (($changed(freq_high) ||
      $changed(src_ext)) |-> $past(vsync_rise) && $past(ce))
      else $error("clock switch not aligned to vsync edge");

   a_break_gap: assert property (s_apply |=> s_gap[*3])
      else $error("mux leg open during switch gap");

   a_undefined_kept: assert property (is_cmd && !known_cmd &&
      !apply |=> $stable(pm) && $stable(pend_src) && $stable(pend_freq))
      else $error("undefined command changed clock state");

   a_freq_request: assert property (pll_high_freq_cmd |=>
      pend_freq && pend_freq_high)
      else $error("high frequency request not held pending");

   a_ext_request: assert property (select_external_clock_cmd |=>
      pend_src && pend_src_ext)
      else $error("external source request not held pending");

endmodule : system_clock_control

// ===== bench/host_link_model.sv
`timescale 1ns/10ps
// ***********************************************************
// Host side of the serial command link
// ***********************************************************
module host_link_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   realtime half_ns;

   // Idle link, slow clock until the core clock runs
   initial begin
      sclk = 1'b0;
      mosi = 1'b1;
      half_ns = 46.0;
      // Select rises after time zero so the bit counter sees the edge
      #1 cs_n = 1'b1;
   end

   // One 24-bit header, msb first, clock stopped outside frames
   task automatic send(input logic [23:0] word);
      #3.3;
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         mosi = word[i];
         #(half_ns) sclk = 1'b1;
         #(half_ns) sclk = 1'b0;
      end
      #(half_ns) cs_n = 1'b1;
      mosi = ~mosi; // Released line shows no stale bit
   endtask : send

   // Faster link once the core clock is enabled
   task automatic go_fast();
      half_ns = 17.0;
   endtask : go_fast
endmodule : host_link_model

// ===== bench/system_clock_control_bench.sv
`timescale 1ns/10ps
module system_clock_control_bench;
   logic       mclk = 1'b0;
   logic       rst_n = 1'b1;
   logic       ce = 1'b1;
   logic       xtal_bypass = 1'b0;
   logic       vsync = 1'b0;
   logic [7:0] pclk_div = 8'h00;
   logic       sclk, cs_n, mosi;
   logic       core_clk_en, pll_en, osc_en, xtal_amp_en;
   logic       pll_ref_ext, clk_sel_int, clk_sel_ext, switch_pending;
   logic [2:0] pll_mult;
   int         n_errors = 0;
   int         cmp_count = 0;
   int         cycles = 0;
   logic [7:0] bad [4] = '{8'h50, 8'h68, 8'h7f, 8'h43};

   always #20 mclk = ~mclk;

   system_clock_control #(.PCLK_W(8)) dut (
      .mclk(mclk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .xtal_bypass(xtal_bypass), .vsync(vsync),
      .pclk_div(pclk_div), .core_clk_en(core_clk_en), .pll_en(pll_en),
      .osc_en(osc_en), .xtal_amp_en(xtal_amp_en),
      .pll_ref_ext(pll_ref_ext), .pll_mult(pll_mult),
      .clk_sel_int(clk_sel_int), .clk_sel_ext(clk_sel_ext),
      .switch_pending(switch_pending)
   );

   host_link_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));

   // ***********************************************************
   // Shared helpers
   // ***********************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t compare %0d got %h want %h", $time,
                  cmp_count, seen, exp);
      end
   endtask : check

   task automatic cmd(input logic [23:0] frame);
      host.send(frame);
      repeat (8) @(posedge mclk);
      @(negedge mclk);
   endtask : cmd

   task automatic vsync_rise();
      @(posedge mclk) vsync <= 1'b1;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask : vsync_rise

   task automatic vsync_done();
      @(posedge mclk) vsync <= 1'b0;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
   endtask : vsync_done

   task automatic conclude();
      $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude

   // ***********************************************************
   // Scenarios
   // ***********************************************************
   task automatic test_reset();
      check(core_clk_en, 8'h0);
      check(pll_en, 8'h1);
      check(osc_en, 8'h1);
      check(pll_mult, clk_ctrl_pkg::HIGH_MULT);
      check(clk_sel_int, 8'h1);
      check(switch_pending, 8'h0);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_wake();
      cmd(24'h000000);
      check(core_clk_en, 8'h1);
      check(pll_ref_ext, 8'h0);
      host.go_fast();
      $display("test_wake done");
   endtask : test_wake

   task automatic test_freq();
      cmd({8'h61, 16'h0000});
      check(switch_pending, 8'h1);
      check(pll_mult, clk_ctrl_pkg::HIGH_MULT);
      vsync_rise();
      vsync_done();
      check(pll_mult, clk_ctrl_pkg::HIGH_MULT);
      check(switch_pending, 8'h1);
      @(posedge mclk) pclk_div <= 8'h05;
      vsync_rise();
      check(core_clk_en, 8'h0);
      check(clk_sel_int, 8'h0);
      check(clk_sel_ext, 8'h0);
      check(pll_mult, clk_ctrl_pkg::LOW_MULT);
      check(switch_pending, 8'h0);
      vsync_done();
      check(clk_sel_int, 8'h1);
      check(core_clk_en, 8'h1);
      cmd({8'h62, 16'h0000});
      vsync_rise();
      vsync_done();
      check(pll_mult, clk_ctrl_pkg::HIGH_MULT);
      $display("test_freq done");
   endtask : test_freq

   task automatic test_source();
      cmd({8'h44, 16'h0000});
      check(pll_ref_ext, 8'h0);
      vsync_rise();
      check(clk_sel_ext, 8'h0);
      vsync_done();
      check(pll_ref_ext, 8'h1);
      check(clk_sel_ext, 8'h1);
      check(clk_sel_int, 8'h0);
      check(xtal_amp_en, 8'h1);
      @(posedge mclk) xtal_bypass <= 1'b1;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      check(xtal_amp_en, 8'h0);
      cmd({8'h48, 16'h0000});
      vsync_rise();
      vsync_done();
      check(clk_sel_int, 8'h1);
      check(pll_ref_ext, 8'h0);
      $display("test_source done");
   endtask : test_source

   task automatic test_undefined();
      for (int i = 0; i < 4; i++) begin
         cmd({bad[i], 16'h0000});
         check(switch_pending, 8'h0);
         check(core_clk_en, 8'h1);
      end
      cmd(24'h610001);
      check(switch_pending, 8'h0);
      $display("test_undefined done");
   endtask : test_undefined

   task automatic test_power();
      @(posedge mclk) ce <= 1'b0;
      cmd({8'h41, 16'h0000});
      check(core_clk_en, 8'h1);
      @(posedge mclk) ce <= 1'b1;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      check(core_clk_en, 8'h0);
      check(pll_en, 8'h1);
      check(osc_en, 8'h1);
      cmd(24'h000000);
      check(core_clk_en, 8'h1);
      cmd({8'h42, 16'h0000});
      check(core_clk_en, 8'h0);
      check(pll_en, 8'h0);
      check(osc_en, 8'h0);
      cmd(24'h000000);
      check(pll_en, 8'h1);
      check(core_clk_en, 8'h1);
      $display("test_power done");
   endtask : test_power

   // ***********************************************************
   // Main sequence and hang guard
   // ***********************************************************
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         conclude();
      end
   end

   initial begin
      // Falling reset edge also clears the link capture registers
      rst_n <= 1'b0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      test_reset();
      test_wake();
      test_freq();
      test_source();
      test_undefined();
      test_power();
      conclude();
   end
endmodule : system_clock_control_bench
